// File: attr_pkg.sv
// Shared constants and types for the master port attribute generator.
//------------------------------------------------------------------------------
// Behaviour
// RL1: Plain ports carry no ID; coherent ports one bit.
// RL2: Every transfer uses full bus width size.
// RL3: Instruction peripheral prot 100, or 110 when nonsecure.
// RL4: Full data peripheral cache is 0011.
// RL5: Data peripheral prot 000, or 010 when nonsecure.
// RL6: Full data peripheral QoS is 1000.
// RL7: Instruction cache line fetches use cache 1111.
// RL8: Coherent DVM requests use cache 0010.
// RL9: Coherent cache ports use inner shareable domain.
// RL10: Instruction cache prot 100, or 110 nonsecure.
// RL11: Instruction cache read QoS is 0111.
// RL12: Plain data cache exclusive uses 0010, else 1111.
// RL13: Coherent data cache reads keep 1111 except DVM.
// RL14: Data cache prot 000, or 010 when nonsecure.
// RL15: Data cache read QoS is 1100.
// RL16: Data cache write QoS is 1000.
// RL17: Instruction cache address widens with address extension.
// RL18: Data cache address width follows address size.
// RL19: Exclusive data peripheral support selects full protocol.
// RL20: Attributes hold stable while a request is valid.
//------------------------------------------------------------------------------
package attr_pkg;

  // Protection encodings, unprivileged in every case.
  localparam logic [2:0] PROT_INSTR_SECURE = 3'h4;
  localparam logic [2:0] PROT_INSTR_NONSEC = 3'h6;
  localparam logic [2:0] PROT_DATA_SECURE = 3'h0;
  localparam logic [2:0] PROT_DATA_NONSEC = 3'h2;

  // Memory type encodings.
  localparam logic [3:0] CACHE_NONE = 4'h0;
  localparam logic [3:0] CACHE_NORMAL_BUF = 4'h3;
  localparam logic [3:0] CACHE_NORMAL_NOBUF = 4'h2;
  localparam logic [3:0] CACHE_WB_ALLOC = 4'hf;

  // Quality of service priorities.
  localparam logic [3:0] QOS_NONE = 4'h0;
  localparam logic [3:0] QOS_DATA_PERIPH = 4'h8;
  localparam logic [3:0] QOS_INSTR_CACHE = 4'h7;
  localparam logic [3:0] QOS_DCACHE_READ = 4'hc;
  localparam logic [3:0] QOS_DCACHE_WRITE = 4'h8;

  // Shareability domains.
  localparam logic [1:0] DOMAIN_NONSHARE = 2'h0;
  localparam logic [1:0] DOMAIN_INNER = 2'h1;

  // Non-secure select bit positions, one per port.
  localparam int NS_DATA_PERIPH = 0;
  localparam int NS_INSTR_PERIPH = 1;
  localparam int NS_DATA_CACHE = 2;
  localparam int NS_INSTR_CACHE = 3;

  // Address and data widths, and the address slot count.
  localparam int ADDR_BASE_W = 32;
  localparam int ADDR_MAX_W = 64;
  localparam int DATA_BASE_W = 32;
  localparam int DATA_MAX_W = 512;
  localparam int SLICE_COUNT = 6;

  // Register map, byte addresses on the APB port.
  localparam logic [11:0] ADDR_NS_SEL = 12'h000;
  localparam logic [11:0] ADDR_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_BUSY = 12'h008;
  localparam logic [3:0] NS_SEL_RESET = 4'h0;

  // Attribute bundle carried beside every address.
  typedef struct packed {
    logic id;
    logic lock;
    logic [2:0] size;
    logic [2:0] prot;
    logic [3:0] cache;
    logic [3:0] qos;
    logic [1:0] domain;
  } ax_attr_t;

  // Transfer size code for a full-width beat.
  function automatic logic [2:0] full_size(input int data_w);
    full_size = 3'($clog2(data_w / 8));
  endfunction

endpackage

// File: attr_cfg_if.sv
// Configuration and status bundle between the register slave and the core.
interface attr_cfg_if;
  logic [3:0] ns_sel; // Per-port non-secure selects.
  logic [attr_pkg::SLICE_COUNT-1:0] busy; // Pending address slots.

  modport regs (
    output ns_sel,
    input busy
  );

  modport core (
    input ns_sel,
    output busy
  );
endinterface

// File: addr_slice.sv
// One-entry address slot that holds an address and its attributes steady.
module addr_slice
  import attr_pkg::*;
#(
  parameter int AW = 32
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Upstream request.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [AW-1:0] in_addr,
  input wire attr_pkg::ax_attr_t in_attr,
  // Downstream address channel.
  output logic out_valid,
  input wire logic out_ready,
  output logic [AW-1:0] out_addr,
  output attr_pkg::ax_attr_t out_attr
);

  logic valid_q; // Slot holds a request.
  logic [AW-1:0] addr_q; // Held address.
  ax_attr_t attr_q; // Held attributes.

  // The slot accepts only when empty or draining, so the held fields
  // cannot move while valid is up and unaccepted.
  assign in_ready = !valid_q || out_ready;

  // ---------------------------------------------------------------------------
  // Slot occupancy.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      valid_q <= 1'b0;
    end else if (in_ready) begin
      valid_q <= in_valid;
    end
  end

  // Payload loads only on acceptance of a new request.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_q <= '0;
      attr_q <= '0;
    end else if (in_ready && in_valid) begin
      addr_q <= in_addr; // [RL20]
      attr_q <= in_attr; // [RL20]
    end
  end

  assign out_valid = valid_q;
  assign out_addr = addr_q;
  assign out_attr = attr_q;

endmodule

// File: attr_apb_regs.sv
// APB register slave holding the non-secure selects and reporting status.
module attr_apb_regs
  import attr_pkg::*;
#(
  parameter logic [31:0] CONFIG_WORD = 32'h0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side.
  attr_cfg_if.regs cfg
);

  logic [3:0] ns_sel_q; // Non-secure selects.
  logic [31:0] prdata_q; // Read data captured in the setup cycle.
  logic hit; // Address decodes to a register.

  assign hit = (paddr == ADDR_NS_SEL) || (paddr == ADDR_CONFIG) || (paddr == ADDR_BUSY);

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;
  assign cfg.ns_sel = ns_sel_q;

  // ---------------------------------------------------------------------------
  // Write path.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ns_sel_q <= NS_SEL_RESET;
    end else if (psel && penable && pwrite && paddr == ADDR_NS_SEL) begin
      ns_sel_q <= pwdata[3:0];
    end
  end

  // Read data is sampled in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_NS_SEL: prdata_q <= {28'h0, ns_sel_q};
        ADDR_CONFIG: prdata_q <= CONFIG_WORD;
        ADDR_BUSY: prdata_q <= {{(32-SLICE_COUNT){1'b0}}, cfg.busy};
        default: prdata_q <= '0;
      endcase
    end
  end

endmodule

// File: axi_master_attribute_gen.sv
// Attribute generator for the four memory-mapped master ports of the core.
//
// The implementer's own choices: the register addresses and the APB slave port.
module axi_master_attribute_gen
  import attr_pkg::*;
#(
  parameter int ADDR_SIZE = 32, // Physical address size for the cache ports.
  parameter bit PHYS_ADDR_EXT = 1'b0, // Address extension widens the instruction cache port.
  parameter bit PERIPH_EXCLUSIVE_ENABLE = 1'b0, // Data peripheral uses full protocol.
  parameter bit IC_COHERENT = 1'b0, // Instruction cache port is coherent.
  parameter bit DC_COHERENT = 1'b0, // Data cache port is coherent.
  parameter int DP_DATA_W = 32, // Data peripheral bus width.
  parameter int IC_DATA_W = 32, // Instruction cache bus width.
  parameter int DC_DATA_W = 32, // Data cache bus width.
  localparam int IC_AW = PHYS_ADDR_EXT ? ADDR_SIZE : attr_pkg::ADDR_BASE_W,
  localparam int DC_AW = ADDR_SIZE
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction peripheral read request.
  input wire logic ip_req_valid,
  output logic ip_req_ready,
  input wire logic [attr_pkg::ADDR_BASE_W-1:0] ip_req_addr,
  // Instruction peripheral read address channel.
  output logic ip_arvalid,
  input wire logic ip_arready,
  output logic [attr_pkg::ADDR_BASE_W-1:0] ip_araddr,
  output logic [2:0] ip_arprot,
  output logic [2:0] ip_arsize,
  // Data peripheral read request.
  input wire logic dpr_req_valid,
  output logic dpr_req_ready,
  input wire logic [attr_pkg::ADDR_BASE_W-1:0] dpr_req_addr,
  input wire logic dpr_req_excl,
  // Data peripheral read address channel.
  output logic dp_arvalid,
  input wire logic dp_arready,
  output logic [attr_pkg::ADDR_BASE_W-1:0] dp_araddr,
  output logic [2:0] dp_arprot,
  output logic [3:0] dp_arcache,
  output logic [3:0] dp_arqos,
  output logic dp_arlock,
  output logic [2:0] dp_arsize,
  // Data peripheral write request.
  input wire logic dpw_req_valid,
  output logic dpw_req_ready,
  input wire logic [attr_pkg::ADDR_BASE_W-1:0] dpw_req_addr,
  input wire logic dpw_req_excl,
  // Data peripheral write address channel.
  output logic dp_awvalid,
  input wire logic dp_awready,
  output logic [attr_pkg::ADDR_BASE_W-1:0] dp_awaddr,
  output logic [2:0] dp_awprot,
  output logic [3:0] dp_awcache,
  output logic [3:0] dp_awqos,
  output logic dp_awlock,
  output logic [2:0] dp_awsize,
  // Instruction cache read request.
  input wire logic ic_req_valid,
  output logic ic_req_ready,
  input wire logic [IC_AW-1:0] ic_req_addr,
  input wire logic ic_req_dvm,
  input wire logic ic_req_id,
  // Instruction cache read address channel.
  output logic ic_arvalid,
  input wire logic ic_arready,
  output logic [IC_AW-1:0] ic_araddr,
  output logic [2:0] ic_arprot,
  output logic [3:0] ic_arcache,
  output logic [3:0] ic_arqos,
  output logic [1:0] ic_ardomain,
  output logic ic_arid,
  output logic [2:0] ic_arsize,
  // Data cache read request.
  input wire logic dcr_req_valid,
  output logic dcr_req_ready,
  input wire logic [DC_AW-1:0] dcr_req_addr,
  input wire logic dcr_req_excl,
  input wire logic dcr_req_dvm,
  input wire logic dcr_req_id,
  // Data cache read address channel.
  output logic dc_arvalid,
  input wire logic dc_arready,
  output logic [DC_AW-1:0] dc_araddr,
  output logic [2:0] dc_arprot,
  output logic [3:0] dc_arcache,
  output logic [3:0] dc_arqos,
  output logic [1:0] dc_ardomain,
  output logic dc_arlock,
  output logic dc_arid,
  output logic [2:0] dc_arsize,
  // Data cache write request.
  input wire logic dcw_req_valid,
  output logic dcw_req_ready,
  input wire logic [DC_AW-1:0] dcw_req_addr,
  input wire logic dcw_req_excl,
  input wire logic dcw_req_id,
  // Data cache write address channel.
  output logic dc_awvalid,
  input wire logic dc_awready,
  output logic [DC_AW-1:0] dc_awaddr,
  output logic [2:0] dc_awprot,
  output logic [3:0] dc_awcache,
  output logic [3:0] dc_awqos,
  output logic [1:0] dc_awdomain,
  output logic dc_awlock,
  output logic dc_awid,
  output logic [2:0] dc_awsize
);

  // ---------------------------------------------------------------------------
  // Elaboration checks.
  // ---------------------------------------------------------------------------
  // Address sizes outside the supported range have no valid port shape.
  if (ADDR_SIZE < ADDR_BASE_W || ADDR_SIZE > ADDR_MAX_W) begin : g_bad_addr
    $error("ADDR_SIZE must lie between 32 and 64.");
  end
  // Cache bus widths must be powers of two between 32 and 512 bits; the data peripheral bus is 32 or 64.
  if (DP_DATA_W < DATA_BASE_W || DP_DATA_W > DATA_BASE_W * 2 || (DP_DATA_W & (DP_DATA_W - 1)) != 0)
    begin : g_bad_dp
    $error("DP_DATA_W must be 32 or 64.");
  end
  if (IC_DATA_W < DATA_BASE_W || IC_DATA_W > DATA_MAX_W || (IC_DATA_W & (IC_DATA_W - 1)) != 0)
    begin : g_bad_ic
    $error("IC_DATA_W must be a power of two from 32 to 512.");
  end
  if (DC_DATA_W < DATA_BASE_W || DC_DATA_W > DATA_MAX_W || (DC_DATA_W & (DC_DATA_W - 1)) != 0)
    begin : g_bad_dc
    $error("DC_DATA_W must be a power of two from 32 to 512.");
  end

  // ---------------------------------------------------------------------------
  // Register slave.
  // ---------------------------------------------------------------------------
  attr_cfg_if cfg ();

  // Configuration word: read-only view of how the ports were built.
  localparam logic [31:0] CONFIG_WORD = {
    16'h0, 1'b0, 7'(ADDR_SIZE), 4'h0,
    DC_COHERENT, IC_COHERENT, PERIPH_EXCLUSIVE_ENABLE, PHYS_ADDR_EXT
  };

  attr_apb_regs #(
    .CONFIG_WORD(CONFIG_WORD)
  ) u_regs (
    .clk_sys(clk_sys),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg.regs)
  );

  // ---------------------------------------------------------------------------
  // Attribute selection.
  // ---------------------------------------------------------------------------
  ax_attr_t ip_attr; // Instruction peripheral read.
  ax_attr_t dpr_attr; // Data peripheral read.
  ax_attr_t dpw_attr; // Data peripheral write.
  ax_attr_t icr_attr; // Instruction cache read.
  ax_attr_t dcr_attr; // Data cache read.
  ax_attr_t dcw_attr; // Data cache write.
  logic [2:0] ip_prot; // Instruction peripheral protection.
  logic [2:0] dp_prot; // Data peripheral protection.
  logic [2:0] ic_prot; // Instruction cache protection.
  logic [2:0] dc_prot; // Data cache protection.

  // Protection follows the per-port non-secure select; it is sampled into
  // the address slot with the request, so a later register write cannot
  // disturb a request already on the bus.
  always_comb begin
    ip_prot = cfg.ns_sel[NS_INSTR_PERIPH] ? PROT_INSTR_NONSEC : PROT_INSTR_SECURE; // [RL3]
    dp_prot = cfg.ns_sel[NS_DATA_PERIPH] ? PROT_DATA_NONSEC : PROT_DATA_SECURE; // [RL5]
    ic_prot = cfg.ns_sel[NS_INSTR_CACHE] ? PROT_INSTR_NONSEC : PROT_INSTR_SECURE; // [RL10]
    dc_prot = cfg.ns_sel[NS_DATA_CACHE] ? PROT_DATA_NONSEC : PROT_DATA_SECURE; // [RL14]
  end

  // Instruction peripheral: read only, no ID, no cache or QoS fields.
  always_comb begin
    ip_attr = '0;
    ip_attr.size = full_size(DATA_BASE_W); // [RL2]
    ip_attr.prot = ip_prot;
  end

  // Data peripheral: the lite variant carries only protection and size; the full
  // variant adds memory type, priority and exclusive marking.
  always_comb begin
    dpr_attr = '0;
    dpr_attr.size = full_size(DP_DATA_W); // [RL2]
    dpr_attr.prot = dp_prot;
    dpr_attr.cache = CACHE_NONE;
    if (PERIPH_EXCLUSIVE_ENABLE) begin
      dpr_attr.cache = CACHE_NORMAL_BUF; // [RL4]
      dpr_attr.qos = QOS_DATA_PERIPH; // [RL6]
      dpr_attr.lock = dpr_req_excl; // [RL19]
    end
    dpw_attr = dpr_attr;
    dpw_attr.lock = PERIPH_EXCLUSIVE_ENABLE && dpw_req_excl; // [RL19]
  end

  // Instruction cache: line fetches are write-back allocate; a coherent
  // port swaps to non-bufferable for distributed virtual memory requests.
  always_comb begin
    icr_attr = '0;
    icr_attr.size = full_size(IC_DATA_W); // [RL2]
    icr_attr.prot = ic_prot;
    icr_attr.qos = QOS_INSTR_CACHE; // [RL11]
    icr_attr.cache = CACHE_WB_ALLOC; // [RL7]
    icr_attr.domain = DOMAIN_NONSHARE;
    if (IC_COHERENT) begin
      icr_attr.id = ic_req_id; // [RL1]
      icr_attr.domain = DOMAIN_INNER; // [RL9]
      if (ic_req_dvm) begin
        icr_attr.cache = CACHE_NORMAL_NOBUF; // [RL8]
      end
    end
  end

  // Data cache reads: the plain port marks exclusives non-bufferable, the
  // coherent port keeps write-back for exclusives and swaps only for DVM.
  always_comb begin
    dcr_attr = '0;
    dcr_attr.size = full_size(DC_DATA_W); // [RL2]
    dcr_attr.prot = dc_prot;
    dcr_attr.qos = QOS_DCACHE_READ; // [RL15]
    dcr_attr.lock = dcr_req_excl;
    dcr_attr.cache = CACHE_WB_ALLOC;
    dcr_attr.domain = DOMAIN_NONSHARE;
    if (DC_COHERENT) begin
      dcr_attr.id = dcr_req_id; // [RL1]
      dcr_attr.domain = DOMAIN_INNER; // [RL9]
      if (dcr_req_dvm) begin
        dcr_attr.cache = CACHE_NORMAL_NOBUF; // [RL8]
      end else begin
        dcr_attr.cache = CACHE_WB_ALLOC; // [RL13]
      end
    end else if (dcr_req_excl) begin
      dcr_attr.cache = CACHE_NORMAL_NOBUF; // [RL12]
    end
  end

  // Data cache writes: exclusives use non-bufferable on both port forms.
  always_comb begin
    dcw_attr = '0;
    dcw_attr.size = full_size(DC_DATA_W); // [RL2]
    dcw_attr.prot = dc_prot;
    dcw_attr.qos = QOS_DCACHE_WRITE; // [RL16]
    dcw_attr.lock = dcw_req_excl;
    dcw_attr.cache = dcw_req_excl ? CACHE_NORMAL_NOBUF : CACHE_WB_ALLOC; // [RL12]
    dcw_attr.domain = DC_COHERENT ? DOMAIN_INNER : DOMAIN_NONSHARE; // [RL9]
    dcw_attr.id = DC_COHERENT && dcw_req_id; // [RL1]
  end

  // ---------------------------------------------------------------------------
  // Address slots, one per address channel.
  // ---------------------------------------------------------------------------
  ax_attr_t ip_out; // Held instruction peripheral attributes.
  ax_attr_t dpr_out; // Held data peripheral read attributes.
  ax_attr_t dpw_out; // Held data peripheral write attributes.
  ax_attr_t icr_out; // Held instruction cache attributes.
  ax_attr_t dcr_out; // Held data cache read attributes.
  ax_attr_t dcw_out; // Held data cache write attributes.

  addr_slice #(.AW(ADDR_BASE_W)) u_ip (
    .clk_sys(clk_sys), .reset(reset),
    .in_valid(ip_req_valid), .in_ready(ip_req_ready), .in_addr(ip_req_addr), .in_attr(ip_attr),
    .out_valid(ip_arvalid), .out_ready(ip_arready), .out_addr(ip_araddr), .out_attr(ip_out)
  );

  addr_slice #(.AW(ADDR_BASE_W)) u_dpr (
    .clk_sys(clk_sys), .reset(reset),
    .in_valid(dpr_req_valid), .in_ready(dpr_req_ready), .in_addr(dpr_req_addr), .in_attr(dpr_attr),
    .out_valid(dp_arvalid), .out_ready(dp_arready), .out_addr(dp_araddr), .out_attr(dpr_out)
  );

  addr_slice #(.AW(ADDR_BASE_W)) u_dpw (
    .clk_sys(clk_sys), .reset(reset),
    .in_valid(dpw_req_valid), .in_ready(dpw_req_ready), .in_addr(dpw_req_addr), .in_attr(dpw_attr),
    .out_valid(dp_awvalid), .out_ready(dp_awready), .out_addr(dp_awaddr), .out_attr(dpw_out)
  );

  // The instruction cache address is 32 bits unless extension widens it.
  addr_slice #(.AW(IC_AW)) u_icr (
    .clk_sys(clk_sys), .reset(reset),
    .in_valid(ic_req_valid), .in_ready(ic_req_ready), .in_addr(ic_req_addr), .in_attr(icr_attr),
    .out_valid(ic_arvalid), .out_ready(ic_arready), .out_addr(ic_araddr), .out_attr(icr_out)
  ); // [RL17]

  addr_slice #(.AW(DC_AW)) u_dcr (
    .clk_sys(clk_sys), .reset(reset),
    .in_valid(dcr_req_valid), .in_ready(dcr_req_ready), .in_addr(dcr_req_addr), .in_attr(dcr_attr),
    .out_valid(dc_arvalid), .out_ready(dc_arready), .out_addr(dc_araddr), .out_attr(dcr_out)
  ); // [RL18]

  addr_slice #(.AW(DC_AW)) u_dcw (
    .clk_sys(clk_sys), .reset(reset),
    .in_valid(dcw_req_valid), .in_ready(dcw_req_ready), .in_addr(dcw_req_addr), .in_attr(dcw_attr),
    .out_valid(dc_awvalid), .out_ready(dc_awready), .out_addr(dc_awaddr), .out_attr(dcw_out)
  ); // [RL18]

  // Status: which slots hold an unaccepted request.
  assign cfg.busy = {dc_awvalid, dc_arvalid, ic_arvalid, dp_awvalid, dp_arvalid, ip_arvalid};

  // ---------------------------------------------------------------------------
  // Field fan-out from the held attributes.
  // ---------------------------------------------------------------------------
  // All fields come from the slot registers, so they stay put while the
  // matching valid is high and the interconnect has not yet accepted.
  assign ip_arprot = ip_out.prot; // [RL20]
  assign ip_arsize = ip_out.size;

  assign dp_arprot = dpr_out.prot; // [RL20]
  assign dp_arcache = dpr_out.cache;
  assign dp_arqos = dpr_out.qos;
  assign dp_arlock = dpr_out.lock;
  assign dp_arsize = dpr_out.size;

  assign dp_awprot = dpw_out.prot; // [RL20]
  assign dp_awcache = dpw_out.cache;
  assign dp_awqos = dpw_out.qos;
  assign dp_awlock = dpw_out.lock;
  assign dp_awsize = dpw_out.size;

  assign ic_arprot = icr_out.prot; // [RL20]
  assign ic_arcache = icr_out.cache;
  assign ic_arqos = icr_out.qos;
  assign ic_ardomain = icr_out.domain;
  assign ic_arid = icr_out.id;
  assign ic_arsize = icr_out.size;

  assign dc_arprot = dcr_out.prot; // [RL20]
  assign dc_arcache = dcr_out.cache;
  assign dc_arqos = dcr_out.qos;
  assign dc_ardomain = dcr_out.domain;
  assign dc_arlock = dcr_out.lock;
  assign dc_arid = dcr_out.id;
  assign dc_arsize = dcr_out.size;

  assign dc_awprot = dcw_out.prot; // [RL20]
  assign dc_awcache = dcw_out.cache;
  assign dc_awqos = dcw_out.qos;
  assign dc_awdomain = dcw_out.domain;
  assign dc_awlock = dcw_out.lock;
  assign dc_awid = dcw_out.id;
  assign dc_awsize = dcw_out.size;

endmodule

// File: attr_chk.sv
// Checker for the attribute generator, bound to its top module.
module attr_chk (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Watched channels.
  input wire logic ip_req_valid,
  input wire logic ip_req_ready,
  input wire logic [31:0] ip_req_addr,
  input wire logic ip_arvalid,
  input wire logic ip_arready,
  input wire logic [31:0] ip_araddr,
  input wire logic [2:0] ip_arprot,
  input wire logic dp_arvalid,
  input wire logic [2:0] dp_arprot,
  input wire logic [3:0] dp_arcache,
  input wire logic [3:0] dp_arqos,
  input wire logic ic_arvalid,
  input wire logic [3:0] ic_arqos,
  input wire logic [1:0] ic_ardomain,
  input wire logic [2:0] ic_arsize,
  input wire logic dc_arvalid,
  input wire logic [3:0] dc_arcache,
  input wire logic [3:0] dc_arqos,
  input wire logic dc_arlock,
  input wire logic dc_awvalid,
  input wire logic [3:0] dc_awqos,
  input wire logic [2:0] dc_awprot
);
  timeunit 1ns;
  timeprecision 1ps;
  // Written for the bench setup: full peripheral, coherent instruction cache, plain data cache.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_ip_take: assert property (ip_req_valid && ip_req_ready |=> ip_arvalid && ip_araddr == $past(ip_req_addr))
    else $error("accepted address not forwarded");
  a_ip_hold: assert property (ip_arvalid && !ip_arready |=> ip_arvalid && $stable(ip_arprot))
    else $error("stalled request changed");
  a_ip_prot: assert property (ip_arvalid |-> ip_arprot inside {3'h4, 3'h6})
    else $error("bad instruction peripheral prot");
  a_dp_prot: assert property (dp_arvalid |-> dp_arprot inside {3'h0, 3'h2})
    else $error("bad data peripheral prot");
  a_dp_attr: assert property (dp_arvalid |-> dp_arcache == 4'h3 && dp_arqos == 4'h8)
    else $error("bad data peripheral cache or qos");
  a_ic_attr: assert property (ic_arvalid |-> ic_arqos == 4'h7 && ic_ardomain == 2'h1 && ic_arsize == 3'h2)
    else $error("bad instruction cache attributes");
  a_dc_cache: assert property (dc_arvalid |-> dc_arcache == (dc_arlock ? 4'h2 : 4'hf))
    else $error("bad data cache memory type");
  a_dc_qos: assert property (dc_arvalid |-> dc_arqos == 4'hc)
    else $error("bad data cache read qos");
  a_dc_write: assert property (dc_awvalid |-> dc_awqos == 4'h8 && dc_awprot inside {3'h0, 3'h2})
    else $error("bad data cache write attributes");
endmodule

bind axi_master_attribute_gen attr_chk u_chk (.*);

// File: addr_sink.sv
// Far-side model: address channel ready, prompt or stalling every other cycle.
module addr_sink (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic slow,
  output logic [5:0] rdy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic t_q; // Toggles each cycle to pace a slow interconnect.
  always_ff @(posedge clk_sys) begin
    if (reset) t_q <= 1'b0;
    else t_q <= ~t_q;
  end
  assign rdy = slow ? {6{t_q}} : 6'h3f;
endmodule

// File: tb.sv
// Testbench: attribute values per port across eight of the sixteen select settings and both flag settings.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import attr_pkg::*;
  logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rq_v = 0, rq_f = 0, slow = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rq_a = 32'h0, rd;
  logic [31:0] ip_req_addr, ip_araddr, dpr_req_addr, dp_araddr, dpw_req_addr, dp_awaddr, ic_req_addr, ic_araddr,
    dcr_req_addr, dc_araddr, dcw_req_addr, dc_awaddr;
  logic [3:0] dp_arcache, dp_arqos, dp_awcache, dp_awqos, ic_arcache, ic_arqos, dc_arcache, dc_arqos, dc_awcache, dc_awqos;
  logic [2:0] ip_arprot, ip_arsize, dp_arprot, dp_arsize, dp_awprot, dp_awsize, ic_arprot, ic_arsize, dc_arprot,
    dc_arsize, dc_awprot, dc_awsize;
  logic [1:0] ic_ardomain, dc_ardomain, dc_awdomain;
  logic ip_req_valid, ip_req_ready, ip_arvalid, ip_arready, dpr_req_valid, dpr_req_ready, dpr_req_excl, dp_arvalid,
    dp_arready, dp_arlock, dpw_req_valid, dpw_req_ready, dpw_req_excl, dp_awvalid, dp_awready, dp_awlock, ic_req_valid,
    ic_req_ready, ic_req_dvm, ic_req_id, ic_arvalid, ic_arready, ic_arid, dcr_req_valid, dcr_req_ready, dcr_req_excl,
    dcr_req_dvm, dcr_req_id, dc_arvalid, dc_arready, dc_arlock, dc_arid, dcw_req_valid, dcw_req_ready, dcw_req_excl,
    dcw_req_id, dc_awvalid, dc_awready, dc_awlock, dc_awid, er;
  logic [5:0] rdy;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // All six channels are requested together; the flag drives exclusive, DVM and ID alike.
  assign {ip_req_valid, dpr_req_valid, dpw_req_valid, ic_req_valid, dcr_req_valid, dcw_req_valid} = {6{rq_v}};
  assign {dpr_req_excl, dpw_req_excl, ic_req_dvm, ic_req_id, dcr_req_excl, dcr_req_dvm, dcr_req_id, dcw_req_excl,
    dcw_req_id} = {9{rq_f}};
  assign {ip_req_addr, dpr_req_addr, dpw_req_addr, ic_req_addr, dcr_req_addr, dcw_req_addr} = {6{rq_a}};
  assign {ip_arready, dp_arready, dp_awready, ic_arready, dc_arready, dc_awready} = rdy;
  axi_master_attribute_gen #(.PERIPH_EXCLUSIVE_ENABLE(1'b1), .IC_COHERENT(1'b1)) uut (.*);
  addr_sink sink (.clk_sys(clk_sys), .reset(reset), .slow(slow), .rdy(rdy));
  always #12.5 clk_sys = ~clk_sys;
  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One APB transfer; waits for pready with the request held.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Request every channel once and compare what comes out.
  task automatic run(input logic [3:0] s, input logic f, input logic sl, input logic [31:0] a);
    apb(1'b1, 12'h000, {28'h0, s}, er);
    rq_v <= 1'b1;
    rq_f <= f;
    rq_a <= a;
    slow <= sl;
    @(posedge clk_sys);
    rq_v <= 1'b0;
    #1;
    chk(ip_arprot, s[1] ? 3'h6 : 3'h4);
    chk({dp_arprot, dp_awprot}, {2{s[0] ? 3'h2 : 3'h0}});
    chk({dp_arcache, dp_awcache, dp_arqos, dp_awqos}, 16'h3388);
    chk({ic_arcache, ic_arqos, ic_ardomain, ic_arid}, {f ? 4'h2 : 4'hf, 4'h7, 2'h1, f});
    chk(ic_arprot, s[3] ? 3'h6 : 3'h4);
    chk({dc_arcache, dc_awcache}, {2{f ? 4'h2 : 4'hf}});
    chk({dc_arprot, dc_awprot}, {2{s[2] ? 3'h2 : 3'h0}});
    chk({dc_arqos, dc_awqos, dc_arid, dc_awid, dc_ardomain, dc_awdomain}, 14'h3200);
    chk({ip_arsize, dp_arsize, dp_awsize, ic_arsize, dc_arsize, dc_awsize}, {6{3'h2}});
    chk({dp_arlock, dp_awlock, dc_arlock, dc_awlock}, {4{f}});
    chk({ic_araddr, dc_awaddr}, {2{a}});
    chk({dp_araddr, dc_araddr}, {2{a}});
    apb(1'b1, 12'h000, {28'h0, ~s}, er);
    while ({ip_arvalid, dp_arvalid, dp_awvalid, ic_arvalid, dc_arvalid, dc_awvalid} != 6'h0) @(posedge clk_sys);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 12'h000, 32'h0, er);
    chk(rd[3:0], 4'h0);
    apb(1'b0, 12'h004, 32'h0, er);
    chk(rd[14:0], 15'h2006);
    apb(1'b0, 12'h00c, 32'h0, er);
    chk({er, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) run(4'(i * 3), i[1], i[2], 32'h8000_0040 + 32'(i * 64));
    end_of_test();
  end
endmodule
